// >>> src/address_matcher.v
/*
 * Parallel compare of a received seven-bit address against the hardware
 * address and every enabled programmable address. Purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "group_addr_regs.vh"

module address_matcher (
	input  wire [6:0]  rx_address,
	input  wire [6:0]  hw_address,
	input  wire [11:0] sub_addr_bits,
	input  wire [2:0]  sub_addr_enable,
	input  wire [3:0]  group_call_addr_bits,
	input  wire        group_call_enable,
	output wire        address_hit
);

	wire [2:0] sub_hit;

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_sub
			// only the upper seven bits take part in the compare
			// enable vector holds sub one in its top bit
			assign sub_hit[i] = sub_addr_enable[2-i] &&
				(rx_address == {`ADDR_FIXED_TOP, sub_addr_bits[4*i+3:4*i]});
		end
	endgenerate

	wire group_hit = group_call_enable &&
		(rx_address == {`ADDR_FIXED_TOP, group_call_addr_bits});

	assign address_hit = (rx_address == hw_address) || (|sub_hit) || group_hit;

endmodule // address_matcher

`default_nettype wire

// >>> src/group_addr_regs.vh
/*
 * Register offsets, field positions and reset values of the group address
 * recognition logic. Assumes inclusion by plain name from each design file that uses its macros.
 */
`ifndef GROUP_ADDR_REGS_VH
`define GROUP_ADDR_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_MODE_REG_ONE       5'h00
`define OFS_SUB_ADDRESS_ONE    5'h18
`define OFS_SUB_ADDRESS_TWO    5'h19
`define OFS_SUB_ADDRESS_THREE  5'h1a
`define OFS_GROUP_CALL_ADDRESS 5'h1b

// ****************************************************************
// mode_reg_one fields
// ****************************************************************
`define BIT_SUB_ONE_ENABLE     3
`define BIT_SUB_TWO_ENABLE     2
`define BIT_SUB_THREE_ENABLE   1
`define BIT_GROUP_CALL_ENABLE  0
`define RST_SUB_ENABLES        3'h0
`define RST_GROUP_CALL_ENABLE  1'h1

// ****************************************************************
// programmable address fields
// ****************************************************************
`define ADDR_FIXED_TOP         3'h6
`define RST_SUB_ONE_BITS       4'h9
`define RST_SUB_TWO_BITS       4'ha
`define RST_SUB_THREE_BITS     4'hc
`define RST_GROUP_CALL_BITS    4'h8

// ****************************************************************
// bus framing
// ****************************************************************
`define BITS_PER_BYTE          4'h8
`define KIND_ADDRESS           2'h0
`define KIND_POINTER           2'h1
`define KIND_DATA              2'h2

`endif

// >>> src/group_address_target.v
/*
 * I2C target with programmable sub-call and group-call addresses.
 * First data byte after a write address sets the register pointer; later
 * bytes write or read at the pointer, which then advances by one.
 * Assumes SCL and SDA are asynchronous pins resolved open-drain outside,
 * and the hardware address inputs are static straps.
 */
`timescale 1ns/1ps
`default_nettype none
`include "group_addr_regs.vh"

module group_address_target (
	input  wire       clock,
	input  wire       sys_rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output reg        sda_oe,
	input  wire [6:0] hw_address,
	output reg  [3:0] address_enables,
	output reg        bus_selected
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_RX   = 3'h1;
	localparam ST_ACK  = 3'h2;
	localparam ST_TX   = 3'h3;
	localparam ST_RACK = 3'h4;

	// ****************************************************************
	// pin sampling
	// ****************************************************************
	wire [1:0] line_synced;
	wire [6:0] hw_synced;

	pin_sync #(
		.WIDTH       (2),
		.RESET_VALUE (2'h3)
	) u_line_sync (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.pin_level    ({scl_in, sda_in}),
		.synced_level (line_synced)
	);

	pin_sync #(
		.WIDTH       (7),
		.RESET_VALUE (7'h00)
	) u_strap_sync (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.pin_level    (hw_address),
		.synced_level (hw_synced)
	);

	wire scl_now = line_synced[1];
	wire sda_now = line_synced[0];
	reg  scl_last;
	reg  sda_last;

	always @(posedge clock) begin
		if (sys_rst) begin
			scl_last <= 1'b1;
			sda_last <= 1'b1;
		end else begin
			scl_last <= scl_now;
			sda_last <= sda_now;
		end
	end

	wire scl_rise  = scl_now & ~scl_last;
	wire scl_fall  = ~scl_now & scl_last;
	wire bus_start = scl_now & scl_last & sda_last & ~sda_now;
	wire bus_stop  = scl_now & scl_last & ~sda_last & sda_now;

	// ****************************************************************
	// registers
	// ****************************************************************
	reg [2:0]  sub_addr_enable;
	reg        group_call_enable;
	reg [11:0] sub_addr_bits;
	reg [3:0]  group_call_addr_bits;
	reg [4:0]  reg_pointer;

	function [7:0] read_value;
		input [4:0]  ptr;
		input [2:0]  sub_en;
		input        grp_en;
		input [11:0] sub_bits;
		input [3:0]  grp_bits;
		begin
			case (ptr)
				`OFS_MODE_REG_ONE:
					read_value = {4'h0, sub_en, grp_en};
				`OFS_SUB_ADDRESS_ONE:
					read_value = {`ADDR_FIXED_TOP, sub_bits[3:0], 1'b0};
				`OFS_SUB_ADDRESS_TWO:
					read_value = {`ADDR_FIXED_TOP, sub_bits[7:4], 1'b0};
				`OFS_SUB_ADDRESS_THREE:
					read_value = {`ADDR_FIXED_TOP, sub_bits[11:8], 1'b0};
				`OFS_GROUP_CALL_ADDRESS:
					read_value = {`ADDR_FIXED_TOP, grp_bits, 1'b0};
				default:
					read_value = 8'h00;
			endcase
		end
	endfunction

	// ****************************************************************
	// address compare
	// ****************************************************************
	reg  [7:0] shift_byte;
	wire       address_hit;

	address_matcher u_matcher (
		.rx_address           (shift_byte[7:1]),
		.hw_address           (hw_synced),
		.sub_addr_bits        (sub_addr_bits),
		.sub_addr_enable      (sub_addr_enable),
		.group_call_addr_bits (group_call_addr_bits),
		.group_call_enable    (group_call_enable),
		.address_hit          (address_hit)
	);

	// ****************************************************************
	// bus engine
	// ****************************************************************
	reg [2:0] state;
	reg [3:0] bit_count;
	reg [1:0] byte_kind;
	reg       read_mode;
	reg       master_acked;

	wire [7:0] pointed_value = read_value(reg_pointer, sub_addr_enable, group_call_enable,
		sub_addr_bits, group_call_addr_bits);

	// open drain: the line is only ever pulled low
	assign sda_out = 1'b0;

	always @(posedge clock) begin
		if (sys_rst) begin
			state                <= ST_IDLE;
			bit_count            <= 4'h0;
			byte_kind            <= `KIND_ADDRESS;
			read_mode            <= 1'b0;
			master_acked         <= 1'b0;
			shift_byte           <= 8'h00;
			sda_oe               <= 1'b0;
			bus_selected         <= 1'b0;
			reg_pointer          <= 5'h00;
			sub_addr_enable      <= `RST_SUB_ENABLES;
			group_call_enable    <= `RST_GROUP_CALL_ENABLE;
			sub_addr_bits        <= {`RST_SUB_THREE_BITS, `RST_SUB_TWO_BITS,
				`RST_SUB_ONE_BITS};
			group_call_addr_bits <= `RST_GROUP_CALL_BITS;
		end else if (bus_start) begin
			state        <= ST_RX;
			bit_count    <= 4'h0;
			byte_kind    <= `KIND_ADDRESS;
			sda_oe       <= 1'b0;
			bus_selected <= 1'b0;
		end else if (bus_stop) begin
			state        <= ST_IDLE;
			sda_oe       <= 1'b0;
			bus_selected <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise && bit_count != `BITS_PER_BYTE) begin
						shift_byte <= {shift_byte[6:0], sda_now};
						bit_count  <= bit_count + 4'h1;
					end else if (scl_fall && bit_count == `BITS_PER_BYTE) begin
						case (byte_kind)
							`KIND_ADDRESS: begin
								if (address_hit) begin
									// read or write alike once matched
									read_mode    <= shift_byte[0];
									bus_selected <= 1'b1;
									sda_oe       <= 1'b1;
									state        <= ST_ACK;
								end else begin
									state <= ST_IDLE;
								end
							end
							`KIND_POINTER: begin
								reg_pointer <= shift_byte[4:0];
								sda_oe      <= 1'b1;
								state       <= ST_ACK;
							end
							default: begin
								case (reg_pointer)
									`OFS_MODE_REG_ONE: begin
										// enables set on the data byte's eighth falling scl edge, with its acknowledge
										sub_addr_enable <= shift_byte[3:1];
										group_call_enable <= shift_byte[`BIT_GROUP_CALL_ENABLE];
									end
									`OFS_SUB_ADDRESS_ONE:
										sub_addr_bits[3:0] <= shift_byte[4:1];
									`OFS_SUB_ADDRESS_TWO:
										sub_addr_bits[7:4] <= shift_byte[4:1];
									`OFS_SUB_ADDRESS_THREE:
										sub_addr_bits[11:8] <= shift_byte[4:1];
									`OFS_GROUP_CALL_ADDRESS:
										// any value, sub-call copies included
										group_call_addr_bits <= shift_byte[4:1];
									default: begin
									end
								endcase
								reg_pointer <= reg_pointer + 5'h01;
								sda_oe      <= 1'b1;
								state       <= ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_count <= 4'h0;
						if (byte_kind == `KIND_ADDRESS && read_mode) begin
							shift_byte  <= pointed_value;
							sda_oe      <= ~pointed_value[7];
							reg_pointer <= reg_pointer + 5'h01;
							state       <= ST_TX;
						end else begin
							sda_oe    <= 1'b0;
							byte_kind <= (byte_kind == `KIND_ADDRESS) ? `KIND_POINTER :
								`KIND_DATA;
							state     <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_count <= bit_count + 4'h1;
					end else if (scl_fall) begin
						if (bit_count == `BITS_PER_BYTE) begin
							sda_oe <= 1'b0;
							state  <= ST_RACK;
						end else begin
							shift_byte <= {shift_byte[6:0], 1'b0};
							sda_oe     <= ~shift_byte[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						master_acked <= ~sda_now;
					end else if (scl_fall) begin
						bit_count <= 4'h0;
						if (master_acked) begin
							shift_byte  <= pointed_value;
							sda_oe      <= ~pointed_value[7];
							reg_pointer <= reg_pointer + 5'h01;
							state       <= ST_TX;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state  <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// status out
	// ****************************************************************
	always @(posedge clock) begin
		if (sys_rst) begin
			address_enables <= {`RST_SUB_ENABLES, `RST_GROUP_CALL_ENABLE};
		end else begin
			address_enables <= {sub_addr_enable, group_call_enable};
		end
	end

endmodule // group_address_target

`default_nettype wire

// >>> src/pin_sync.v
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to clock and idle at RESET_VALUE.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH       = 2,
	parameter RESET_VALUE = 2'h3
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] pin_level,
	output reg  [WIDTH-1:0] synced_level
);

	reg [WIDTH-1:0] meta_level;

	// first stage read only by the second
	always @(posedge clock) begin
		if (sys_rst) begin
			meta_level   <= RESET_VALUE;
			synced_level <= RESET_VALUE;
		end else begin
			meta_level   <= pin_level;
			synced_level <= meta_level;
		end
	end

endmodule // pin_sync

`default_nettype wire

// >>> verif/group_address_target_properties.sv
/* Port checker for group_address_target.
   Assumes bind into every group_address_target instance. */
`timescale 1ns/1ps
`default_nettype none
module gat_checker (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [6:0] hw_address,
	input wire logic [3:0] address_enables,
	input wire logic       bus_selected
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_rst_en; $past(sys_rst) |-> address_enables == 4'h1; endproperty
	a_rst_en: assert property (p_rst_en)
		else $error("enables not at reset value");
	property p_oe_hold; $rose(sda_oe) |-> sda_oe[*4]; endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("sda drive too short");
	property p_oe_scl_low; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("sda drive changed with scl high");
	property p_sel_ack; $rose(bus_selected) |-> ##[0:1] sda_oe; endproperty
	a_sel_ack: assert property (p_sel_ack)
		else $error("selected without acknowledge");
	property p_sel_drop; $fell(bus_selected) |-> $past(scl_in, 2); endproperty
	a_sel_drop: assert property (p_sel_drop)
		else $error("deselected outside start or stop");
	property p_en_sel; $changed(address_enables) |-> $past(bus_selected); endproperty
	a_en_sel: assert property (p_en_sel)
		else $error("enables changed without bus write");
	property p_sda_od; sda_out == 1'b0; endproperty
	a_sda_od: assert property (p_sda_od)
		else $error("sda driven high");
	property p_oe_sel; $rose(sda_oe) |-> ##[0:1] bus_selected; endproperty
	a_oe_sel: assert property (p_oe_sel)
		else $error("acknowledge while not selected");
endmodule // gat_checker
bind group_address_target gat_checker u_chk (.clock(clock), .sys_rst(sys_rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.hw_address(hw_address), .address_enables(address_enables),
	.bus_selected(bus_selected));
`default_nettype wire

// >>> verif/i2c_ctl_model.sv
/* Bus controller model: start, stop, byte write and byte read tasks.
   Assumes sda is the resolved wire with pull-up; scl idles high. */
`timescale 1ns/1ps
`default_nettype none
module i2c_ctl_model (
	input  wire logic clock,
	input  wire logic sda,
	output var logic  scl,
	output var logic  sda_low
);
	// ****************************************************************
	// bit level
	// ****************************************************************
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic half();
		repeat (5) @(negedge clock);
	endtask
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		r = sda;
		scl = 1'b0;
		half();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(nack, r);
	endtask
endmodule // i2c_ctl_model
`default_nettype wire

// >>> verif/test_i2c_group_address_match.sv
/* Self-checking bench for group_address_target.
   Assumes the controller model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_i2c_group_address_match;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic [6:0] hw_address = 7'h60;
	wire        scl;
	wire        sda_low;
	wire        sda_out;
	wire        sda_oe;
	wire  [3:0] address_enables;
	wire        bus_selected;
	wire        sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	int         error_cnt = 0;
	int         cmp_count = 0;
	logic       ack;
	logic [7:0] rd;
	logic [6:0] subs [3] = '{7'h6f, 7'h62, 7'h6d};
	always #4 clock = ~clock;
	group_address_target DUT (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .hw_address(hw_address),
		.address_enables(address_enables), .bus_selected(bus_selected));
	i2c_ctl_model ctl (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [4:0] ptr, input logic [7:0] d);
		ctl.start();
		ctl.wbyte({hw_address, 1'b0}, ack);
		ctl.wbyte({3'h0, ptr}, ack);
		ctl.wbyte(d, ack);
		ctl.stop();
	endtask
	task automatic reg_rd(input logic [4:0] ptr, input logic [7:0] exp, input string what);
		ctl.start();
		ctl.wbyte({hw_address, 1'b0}, ack);
		ctl.wbyte({3'h0, ptr}, ack);
		ctl.start();
		ctl.wbyte({hw_address, 1'b1}, ack);
		ctl.rbyte(1'b1, rd);
		ctl.stop();
		chk(what, exp, rd);
	endtask
	task automatic probe(input logic [6:0] a, input logic rw, input logic exp);
		ctl.start();
		ctl.wbyte({a, rw}, ack);
		chk("selected", {7'h0, exp}, {7'h0, bus_selected});
		if (ack && rw)
			ctl.rbyte(1'b1, rd);
		ctl.stop();
		chk("ack", {7'h0, exp}, {7'h0, ack});
		chk("released", 8'h00, {7'h0, bus_selected});
	endtask
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		chk("enables", 8'h01, {4'h0, address_enables});
		reg_rd(5'h00, 8'h01, "mode");
		reg_rd(5'h18, 8'hd2, "sub1");
		reg_rd(5'h19, 8'hd4, "sub2");
		reg_rd(5'h1a, 8'hd8, "sub3");
		reg_rd(5'h1b, 8'hd0, "group");
		reg_rd(5'h1c, 8'h00, "unmapped");
		probe(7'h69, 1'b0, 1'b0);
		probe(7'h6a, 1'b1, 1'b0);
		probe(7'h6c, 1'b0, 1'b0);
		probe(7'h68, 1'b0, 1'b1);
		probe(7'h68, 1'b1, 1'b1);
		reg_wr(5'h18, 8'h3f);
		reg_wr(5'h19, 8'h05);
		reg_wr(5'h1a, 8'h1b);
		reg_rd(5'h18, 8'hde, "sub1");
		reg_rd(5'h19, 8'hc4, "sub2");
		reg_rd(5'h1a, 8'hda, "sub3");
		reg_wr(5'h00, 8'hff);
		reg_rd(5'h00, 8'h0f, "mode");
		chk("enables", 8'h0f, {4'h0, address_enables});
		for (int i = 0; i < 6; i++) begin
			probe(subs[i / 2], i[0], 1'b1);
		end
		reg_wr(5'h1b, 8'hde);
		reg_rd(5'h1b, 8'hde, "group");
		probe(7'h6f, 1'b0, 1'b1);
		reg_wr(5'h1b, 8'h2a);
		reg_rd(5'h1b, 8'hca, "group");
		probe(7'h65, 1'b0, 1'b1);
		probe(7'h65, 1'b1, 1'b1);
		probe(7'h68, 1'b0, 1'b0);
		reg_wr(5'h00, 8'h0e);
		chk("enables", 8'h0e, {4'h0, address_enables});
		probe(7'h65, 1'b0, 1'b0);
		probe(7'h6d, 1'b1, 1'b1);
		reg_wr(5'h00, 8'h08);
		chk("enables", 8'h08, {4'h0, address_enables});
		probe(7'h6f, 1'b0, 1'b1);
		probe(7'h62, 1'b0, 1'b0);
		probe(7'h6d, 1'b1, 1'b0);
		reg_wr(5'h00, 8'h00);
		probe(7'h6f, 1'b0, 1'b0);
		probe(7'h62, 1'b1, 1'b0);
		probe(hw_address, 1'b0, 1'b1);
		print_verdict();
	end
endmodule // test_i2c_group_address_match
`default_nettype wire
